// ### hdl/i2c_mem_front_end.sv
`timescale 1ns/10ps
`default_nettype none
`include "i2c_mem_defines.svh"

// Operation
// RULE_01 - Respond only when select code matches pins.
// RULE_02 - Unconnected select pins read as low.
// RULE_03 - Data line only pulled low, else released.
// RULE_04 - Sample on clock rise, change on fall.
// RULE_05 - Write protect high blocks every memory write.
// RULE_06 - Reads work regardless of write protect.
// RULE_07 - Unconnected write protect reads low, writable.
// RULE_08 - Master alone starts transfers and drives clock.
// RULE_09 - Data changes only while clock is low.
// RULE_10 - Detect start and stop conditions.
// RULE_11 - Stop ends transfer, back to standby.
// RULE_12 - New transfer accepted at once after write.
// RULE_13 - Receiver pulls low on ninth clock.
// RULE_14 - Transmitter releases line on ninth clock.
// RULE_15 - Stop before acknowledge abandons the operation.
// RULE_16 - Release bus after not-acknowledge.
// RULE_17 - Master follows release with stop or start.
// RULE_18 - Address word: type, select, direction order.
// RULE_19 - Upper four bits must match device type.
// RULE_20 - Master clock at most 1 MHz; the bench master clocks 160 ns bits (6.25 MHz).
// RULE_21 - Memory holds 8192 bytes.
// RULE_22 - Select bits arrive most significant first.
// RULE_23 - Direction bit: 0 write, 1 read.
// RULE_24 - Mismatch: no acknowledge, standby until start.
// RULE_25 - Two address bytes, then acknowledged data bytes.
// RULE_26 - Unselected device never drives the data line.
module i2c_mem_front_end #(
	// Device type identifier; the value is arbitrary.
	parameter logic [`TYPE_W-1:0] DEVICE_TYPE_ID = 4'h6
) (
	input  wire logic I_CLK,
	input  wire logic I_RST,
	input  wire logic I_SCL,
	input  wire logic I_SDA,
	input  wire logic I_SELECT_PIN_BIT0,
	input  wire logic I_SELECT_PIN_BIT1,
	input  wire logic I_SELECT_PIN_BIT2,
	input  wire logic I_WP,
	input  wire logic I_WRITE_HOLD,
	output var  logic O_SDA_OUT,
	output var  logic O_SDA_OE,
	output var  logic O_SELECTED,
	output var  logic O_READ_MODE,
	output var  logic O_WP_REJECT
);

	import i2c_mem_pkg::*;

	logic [`SYNC_BITS-1:0]  sync_in;
	logic [`SYNC_BITS-1:0]  sync_out;
	logic                   scl_s;
	logic                   sda_s;
	logic                   wp_s;
	logic [`SEL_W-1:0]      sel_pins;
	logic                   scl_prev_reg;
	logic                   sda_prev_reg;
	logic                   scl_rise;
	logic                   scl_fall;
	logic                   start_cond;
	logic                   stop_cond;
	phase_e                 phase_reg;
	phase_e                 after_ack;
	logic [3:0]             bit_cnt_reg;
	logic [`BYTE_W-1:0]     shift_reg;
	logic [`BYTE_W-1:0]     tx_reg;
	logic [`MEM_ADDR_W-1:0] addr_reg;
	logic                   dir_reg;
	logic                   master_nack_reg;
	logic                   sda_oe_reg;
	logic                   sda_out_reg;
	logic                   selected_reg;
	logic                   read_mode_reg;
	logic                   wp_reject_reg;
	logic                   ack_begin;
	logic                   ack_end;
	logic                   dev_match;
	logic                   ack_now;
	logic [`BYTE_W-1:0]     rd_word;
	logic [`BYTE_W-1:0]     mem_array [`MEM_WORDS];
	wr_entry_s              fifo_in;
	wr_entry_s              fifo_out;
	logic                   fifo_in_valid;
	logic                   fifo_in_ready;
	logic                   fifo_out_valid;
	logic                   fifo_out_ready;

	// Pins pass two flops; the lines enter inverted so a cleared chain reads as an idle bus.
	assign sync_in = {I_WP, I_SELECT_PIN_BIT2, I_SELECT_PIN_BIT1, I_SELECT_PIN_BIT0,
		~I_SDA, ~I_SCL};

	bit_sync #(
		.WIDTH (`SYNC_BITS)
	) u_pin_sync (
		.i_clk   (I_CLK),
		.i_rst   (I_RST),
		.i_async (sync_in),
		.o_sync  (sync_out)
	);

	// Open select and protect pins are pulled down outside, so they read low.
	assign scl_s    = ~sync_out[0]; // High after reset, so no false edge follows it.
	assign sda_s    = ~sync_out[1];
	assign sel_pins = sync_out[4:2]; // [RULE_02]
	assign wp_s     = sync_out[5]; // [RULE_07]

	// Previous line levels for edge and condition detection.
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_prev_reg <= scl_s;
			sda_prev_reg <= sda_s;
		end
	end

	// Clock edges, and data edges while the clock stays high.
	assign scl_rise   = scl_s && !scl_prev_reg;
	assign scl_fall   = !scl_s && scl_prev_reg;
	assign start_cond = scl_s && scl_prev_reg && sda_prev_reg && !sda_s; // [RULE_10]
	assign stop_cond  = scl_s && scl_prev_reg && !sda_prev_reg && sda_s; // [RULE_10]

	// The acknowledge slot opens on the fall after the eighth bit and closes on the next.
	assign ack_begin = scl_fall && (bit_cnt_reg == `CNT_ACK) && (phase_reg != PH_IDLE);
	assign ack_end   = scl_fall && (bit_cnt_reg == `CNT_ACK_END) && (phase_reg != PH_IDLE);

	// Address word match compares the type and select fields; the direction bit is not compared.
	assign dev_match = (shift_reg[`TYPE_MSB:`TYPE_LSB] == DEVICE_TYPE_ID) && // [RULE_19]
		(shift_reg[`SEL_MSB:`SEL_LSB] == sel_pins); // [RULE_01] [RULE_22] [RULE_18]

	// Decide whether this byte is acknowledged by pulling the line low.
	always_comb begin
		case (phase_reg)
			PH_DEV:     ack_now = dev_match; // [RULE_24] [RULE_26]
			PH_ADDR_HI: ack_now = 1'b1; // [RULE_25]
			PH_ADDR_LO: ack_now = 1'b1; // [RULE_25]
			PH_WRITE:   ack_now = fifo_in_ready; // [RULE_13]
			PH_READ:    ack_now = 1'b0; // [RULE_14]
			default:    ack_now = 1'b0;
		endcase
	end

	// Phase that follows a completed acknowledge slot.
	always_comb begin
		case (phase_reg)
			PH_DEV:     after_ack = dir_reg ? PH_READ : PH_ADDR_HI; // [RULE_23]
			PH_ADDR_HI: after_ack = PH_ADDR_LO;
			PH_ADDR_LO: after_ack = PH_WRITE;
			PH_WRITE:   after_ack = PH_WRITE;
			PH_READ:    after_ack = master_nack_reg ? PH_IDLE : PH_READ; // [RULE_16]
			default:    after_ack = PH_IDLE;
		endcase
	end

	// Transfer phase: start opens, stop or refusal returns to standby.
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			phase_reg <= PH_IDLE;
		end else if (start_cond) begin
			phase_reg <= PH_DEV; // [RULE_10] [RULE_12]
		end else if (stop_cond) begin
			phase_reg <= PH_IDLE; // [RULE_11] [RULE_15]
		end else if (ack_begin && !ack_now && (phase_reg != PH_READ)) begin
			phase_reg <= PH_IDLE; // [RULE_24] [RULE_16]
		end else if (ack_end) begin
			phase_reg <= after_ack;
		end
	end

	// Bit counter: eight data clocks, the acknowledge clock, then wrap.
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			bit_cnt_reg <= `CNT_ZERO;
		end else if (start_cond) begin
			bit_cnt_reg <= `CNT_ZERO;
		end else if (ack_end) begin
			bit_cnt_reg <= `CNT_ZERO; // [RULE_13]
		end else if (scl_rise && (phase_reg != PH_IDLE) && (bit_cnt_reg < `CNT_ACK_END)) begin
			bit_cnt_reg <= bit_cnt_reg + 4'h1;
		end
	end

	// Incoming bits are sampled on the rising clock edge, most significant first.
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			shift_reg <= 8'h00;
		end else if (scl_rise && (bit_cnt_reg < `CNT_ACK)) begin
			shift_reg <= {shift_reg[`BYTE_W-2:0], sda_s}; // [RULE_04] [RULE_18]
		end
	end

	// Direction flag is captured once the address word is accepted.
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			dir_reg <= 1'b0;
		end else if (ack_begin && (phase_reg == PH_DEV) && dev_match) begin
			dir_reg <= shift_reg[`DIR_BIT]; // [RULE_23]
		end
	end

	// The master's acknowledge level is sampled on the ninth rising edge of a read.
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			master_nack_reg <= 1'b0;
		end else if (start_cond) begin
			master_nack_reg <= 1'b0;
		end else if (scl_rise && (phase_reg == PH_READ) && (bit_cnt_reg == `CNT_ACK)) begin
			master_nack_reg <= sda_s; // [RULE_16]
		end
	end

	// Memory address counter: loaded from two bytes, advanced per data byte.
	assign rd_word = mem_array[addr_reg];

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			addr_reg <= 13'h0000;
		end else if (ack_begin && (phase_reg == PH_ADDR_HI)) begin
			addr_reg[`MEM_ADDR_W-1:`BYTE_W] <= shift_reg[`ADDR_HI_MSB:0]; // [RULE_25]
		end else if (ack_begin && (phase_reg == PH_ADDR_LO)) begin
			addr_reg[`BYTE_W-1:0] <= shift_reg; // [RULE_25]
		end else if (ack_begin && (phase_reg == PH_WRITE) && fifo_in_ready) begin
			addr_reg <= addr_reg + 13'h0001;
		end else if (ack_end && (after_ack == PH_READ)) begin
			addr_reg <= addr_reg + 13'h0001; // [RULE_06]
		end
	end

	// Outgoing read byte: loaded at the end of an acknowledge, shifted on falls.
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			tx_reg <= 8'h00;
		end else if (ack_end && (after_ack == PH_READ)) begin
			tx_reg <= rd_word; // [RULE_06]
		end else if (scl_fall && (phase_reg == PH_READ) && (bit_cnt_reg != `CNT_ZERO) &&
			(bit_cnt_reg < `CNT_ACK)) begin
			tx_reg <= {tx_reg[`BYTE_W-2:0], 1'b0}; // [RULE_04]
		end
	end

	// Data line driver: changes on clock falls, is released at once by start, stop or standby, and only ever pulls low.
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			sda_oe_reg <= 1'b0;
		end else if (start_cond || stop_cond) begin
			sda_oe_reg <= 1'b0; // [RULE_11] [RULE_15]
		end else if (ack_begin) begin
			sda_oe_reg <= ack_now; // [RULE_13] [RULE_14] [RULE_26]
		end else if (ack_end) begin
			sda_oe_reg <= (after_ack == PH_READ) ? !rd_word[`BYTE_W-1] : 1'b0; // [RULE_16]
		end else if (scl_fall && (phase_reg == PH_READ) && (bit_cnt_reg != `CNT_ZERO) &&
			(bit_cnt_reg < `CNT_ACK)) begin
			sda_oe_reg <= !tx_reg[`BYTE_W-2]; // [RULE_09] [RULE_04]
		end else if (phase_reg == PH_IDLE) begin
			sda_oe_reg <= 1'b0; // [RULE_26]
		end
	end

	// The driven level is always low; the pull-up supplies the high level.
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			sda_out_reg <= 1'b0;
		end else begin
			sda_out_reg <= 1'b0; // [RULE_03]
		end
	end

	// Write bytes go to the FIFO unless write protect is high.
	assign fifo_in.addr   = addr_reg;
	assign fifo_in.data   = shift_reg;
	assign fifo_in_valid  = ack_begin && (phase_reg == PH_WRITE) && !wp_s; // [RULE_05]
	assign fifo_out_ready = !I_WRITE_HOLD;

	sync_fifo #(
		.WIDTH ($bits(wr_entry_s)),
		.DEPTH (`WR_FIFO_DEPTH)
	) u_wr_fifo (
		.i_clk       (I_CLK),
		.i_rst       (I_RST),
		.i_in_valid  (fifo_in_valid),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (fifo_in),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (fifo_out_ready),
		.o_out_data  (fifo_out)
	);

	// The array drains the FIFO at core speed unless I_WRITE_HOLD is high; then a full FIFO refuses bytes on the link.
	always_ff @(posedge I_CLK) begin
		if (fifo_out_valid && fifo_out_ready) begin
			mem_array[fifo_out.addr] <= fifo_out.data; // [RULE_21] [RULE_12]
		end
	end

	// Pulse when a protected write byte is acknowledged but discarded.
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			wp_reject_reg <= 1'b0;
		end else begin
			wp_reject_reg <= ack_begin && (phase_reg == PH_WRITE) && wp_s &&
				fifo_in_ready; // [RULE_05]
		end
	end

	// Status: selected once the address word is accepted, and its direction.
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			selected_reg  <= 1'b0;
			read_mode_reg <= 1'b0;
		end else begin
			selected_reg  <= (phase_reg != PH_IDLE) && (phase_reg != PH_DEV);
			read_mode_reg <= (phase_reg == PH_READ);
		end
	end

	assign O_SDA_OUT   = sda_out_reg;
	assign O_SDA_OE    = sda_oe_reg;
	assign O_SELECTED  = selected_reg;
	assign O_READ_MODE = read_mode_reg;
	assign O_WP_REJECT = wp_reject_reg;

endmodule

`default_nettype wire

// ### hdl/i2c_mem_defines.svh
`ifndef I2C_MEM_DEFINES_SVH
`define I2C_MEM_DEFINES_SVH

// Memory geometry.
`define MEM_WORDS        8192
`define MEM_ADDR_W       13
`define BYTE_W           8
// Address word layout: type code, select code, direction flag.
`define TYPE_W           4
`define TYPE_MSB         7
`define TYPE_LSB         4
`define SEL_W            3
`define SEL_MSB          3
`define SEL_LSB          1
`define DIR_BIT          0
// Upper memory address byte carries the top five address bits.
`define ADDR_HI_MSB      4
// Bit counter values: eight data bits, then the acknowledge clock.
`define CNT_ACK          4'h8
`define CNT_ACK_END      4'h9
`define CNT_ZERO         4'h0
// Number of pin bits passed through the synchroniser.
`define SYNC_BITS        6
// Depth of the write FIFO.
`define WR_FIFO_DEPTH    8
// Fastest serial clock the master may use, and its period in ns.
`define LINK_MAX_KHZ     1000
`define LINK_MIN_PERIOD_NS 1000
`define CLK_PERIOD_NS    8
`define LINK_MIN_PERIOD_CYC ((`LINK_MIN_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### hdl/i2c_mem_pkg.sv
`include "i2c_mem_defines.svh"

package i2c_mem_pkg;

	// Transfer phase of the serial front end.
	typedef enum logic [2:0] {
		PH_IDLE,
		PH_DEV,
		PH_ADDR_HI,
		PH_ADDR_LO,
		PH_WRITE,
		PH_READ
	} phase_e;

	// One pending memory write: where and what.
	typedef struct packed {
		logic [`MEM_ADDR_W-1:0] addr;
		logic [`BYTE_W-1:0]     data;
	} wr_entry_s;

endpackage

// ### hdl/bit_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Two-flop synchroniser, one chain per bit.
module bit_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic [WIDTH-1:0] i_async,
	output var  logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_reg;

	// The first stage feeds only the second stage.
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
			always_ff @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					meta_reg[gi] <= 1'b0;
					o_sync[gi]   <= 1'b0;
				end else begin
					meta_reg[gi] <= i_async[gi];
					o_sync[gi]   <= meta_reg[gi];
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// ### hdl/sync_fifo.sv
`timescale 1ns/10ps
`default_nettype none

// Synchronous FIFO with valid and ready on both sides.
module sync_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic             i_in_valid,
	output var  logic             o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output var  logic             o_out_valid,
	input  wire logic             i_out_ready,
	output var  logic [WIDTH-1:0] o_out_data
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PW:0]      wr_ptr_reg;
	logic [PW:0]      rd_ptr_reg;
	logic             push;
	logic             pop;

	// Full when the pointers differ only in the wrap bit; empty when equal.
	assign o_in_ready  = !((wr_ptr_reg[PW] != rd_ptr_reg[PW]) &&
		(wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]));
	assign o_out_valid = (wr_ptr_reg != rd_ptr_reg);
	assign o_out_data  = store[rd_ptr_reg[PW-1:0]];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	// Storage is written only on an accepted push.
	always_ff @(posedge i_clk) begin
		if (push) begin
			store[wr_ptr_reg[PW-1:0]] <= i_in_data;
		end
	end

	// Pointer updates.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

// ### verif/i2c_mem_front_end_props.sv
`timescale 1ns/10ps
`default_nettype none

// Port-level checks on the serial front end.
module i2c_mem_front_end_props (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic I_SCL,
	input wire logic I_SDA,
	input wire logic I_WP,
	input wire logic O_SDA_OUT,
	input wire logic O_SDA_OE,
	input wire logic O_SELECTED,
	input wire logic O_READ_MODE,
	input wire logic O_WP_REJECT
);
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);

	// The pin is only ever pulled low, and a pull starts only while the clock is low.
	property p_sda_out_low;
		O_SDA_OUT == 1'b0;
	endproperty
	a_sda_out_low: assert property (p_sda_out_low) else $error("data driven high");
	property p_oe_rise_scl_low;
		$rose(O_SDA_OE) |-> !I_SCL && !$past(I_SCL, 2);
	endproperty
	a_oe_rise_scl_low: assert property (p_oe_rise_scl_low) else $error("pull while clock high");
	property p_ack_hold;
		$rose(O_SDA_OE) |=> O_SDA_OE [*8];
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("low level cut short");
	// A read phase is entered only straight from an accepted address word.
	property p_read_sel;
		$rose(O_READ_MODE) |-> $rose(O_SELECTED);
	endproperty
	a_read_sel: assert property (p_read_sel) else $error("read while unselected");
	// Stop and start both drop the device back off the line within a few cycles.
	property p_stop_standby;
		I_SCL && $past(I_SCL) && $rose(I_SDA) |-> ##[1:6] (!O_SELECTED && !O_SDA_OE);
	endproperty
	a_stop_standby: assert property (p_stop_standby) else $error("no standby after stop");
	property p_start_release;
		I_SCL && $past(I_SCL) && $fell(I_SDA) |-> ##[1:6] (!O_SELECTED && !O_SDA_OE);
	endproperty
	a_start_release: assert property (p_start_release) else $error("no restart on start");
	property p_wp_pulse;
		O_WP_REJECT |=> !O_WP_REJECT;
	endproperty
	a_wp_pulse: assert property (p_wp_pulse) else $error("reject pulse too long");
	property p_wp_cause;
		O_WP_REJECT |-> $past(I_WP, 3) && O_SELECTED && !O_READ_MODE;
	endproperty
	a_wp_cause: assert property (p_wp_cause) else $error("reject without protect");
endmodule

bind i2c_mem_front_end i2c_mem_front_end_props u_props (
	.I_CLK      (I_CLK),
	.I_RST      (I_RST),
	.I_SCL      (I_SCL),
	.I_SDA      (I_SDA),
	.I_WP       (I_WP),
	.O_SDA_OUT  (O_SDA_OUT),
	.O_SDA_OE   (O_SDA_OE),
	.O_SELECTED (O_SELECTED),
	.O_READ_MODE(O_READ_MODE),
	.O_WP_REJECT(O_WP_REJECT)
);

`default_nettype wire

// ### verif/i2c_master_model.sv
`timescale 1ns/10ps
`default_nettype none

// Bus master: owns the clock, idles high, bit period 20 core cycles (160 ns).
module i2c_master_model (
	input  wire logic i_clk,
	input  wire logic i_sda,
	output var  logic o_scl,
	output var  logic o_sda
);
	localparam int HALF = 9;

	// The master alone drives the clock and starts transfers.
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end

	task automatic wait_half();
		repeat (HALF) @(posedge i_clk);
	endtask

	// Data falls while the clock is high.
	task automatic start_cond();
		repeat (2) @(posedge i_clk);
		o_sda <= 1'b1;
		wait_half();
		o_scl <= 1'b1;
		wait_half();
		o_sda <= 1'b0;
		wait_half();
		o_scl <= 1'b0;
	endtask

	// Data rises while the clock is high; the bus is then left idle.
	task automatic stop_cond();
		repeat (2) @(posedge i_clk);
		o_sda <= 1'b0;
		wait_half();
		o_scl <= 1'b1;
		wait_half();
		o_sda <= 1'b1;
		wait_half();
	endtask

	// Data changes only in the low phase and is sampled at the end of the high phase.
	task automatic xfer_bit(input logic b, output logic r);
		repeat (2) @(posedge i_clk);
		o_sda <= b;
		wait_half();
		o_scl <= 1'b1;
		wait_half();
		r = i_sda;
		o_scl <= 1'b0;
	endtask

	// Eight bits MSB first, then the line is released for the ack.
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(d[i], r);
		end
		xfer_bit(1'b1, ack);
	endtask

	// Receive a byte, then ack it or leave the line high.
	task automatic recv_byte(output logic [7:0] d, input logic nack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(1'b1, d[i]);
		end
		xfer_bit(nack, r);
	endtask
endmodule

`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	import i2c_mem_pkg::*;
	// Type code for the bench; the value is arbitrary.
	localparam logic [3:0] TID  = 4'h6;
	localparam logic [2:0] PINS = 3'h5;
	logic       clk, rst, scl, m_sda, sda, wp, hold;
	logic [2:0] pins;
	logic       sda_out, sda_oe, selected, read_mode, wp_reject;
	int         errors, n_checks, n_rej, cycles;

	// Open-drain wire with pull-up.
	assign sda = m_sda & ~(sda_oe & ~sda_out);

	i2c_mem_front_end #(.DEVICE_TYPE_ID(TID)) dut (
		.I_CLK(clk), .I_RST(rst), .I_SCL(scl), .I_SDA(sda),
		.I_SELECT_PIN_BIT0(pins[0]), .I_SELECT_PIN_BIT1(pins[1]),
		.I_SELECT_PIN_BIT2(pins[2]), .I_WP(wp), .I_WRITE_HOLD(hold),
		.O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .O_SELECTED(selected),
		.O_READ_MODE(read_mode), .O_WP_REJECT(wp_reject)
	);
	i2c_master_model master (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Cycle ceiling and reject-pulse counter.
	always @(posedge clk) begin
		cycles++;
		if (wp_reject === 1'b1) n_rej++;
		if (cycles == 40000) begin
			errors++;
			finish_test();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Start, device word for writing, two address bytes.
	task automatic addr_phase(input logic [12:0] a);
		logic k0, k1, k2;
		master.start_cond();
		master.send_byte({TID, PINS, 1'b0}, k0);
		master.send_byte({3'h0, a[12:8]}, k1);
		master.send_byte(a[7:0], k2);
		check({5'h00, k0, k1, k2}, 8'h00);
	endtask

	// Write n bytes d0, d0+1, ...; byte index nack_at must be refused.
	task automatic wr_bytes(input logic [12:0] a, input logic [7:0] d0, input int n,
	                        input int nack_at);
		logic k;
		addr_phase(a);
		for (int i = 0; i < n; i++) begin
			master.send_byte(d0 + 8'(i), k);
			check({7'h00, k}, {7'h00, i == nack_at});
		end
		master.stop_cond();
	endtask

	// Random read of n bytes, master acks all but the last.
	task automatic rd_check(input logic [12:0] a, input logic [7:0] e0, input int n);
		logic       k;
		logic [7:0] d;
		addr_phase(a);
		master.start_cond();
		master.send_byte({TID, PINS, 1'b1}, k);
		check({7'h00, k}, 8'h00);
		repeat (6) @(posedge clk);
		check({7'h00, read_mode}, 8'h01);
		for (int i = 0; i < n; i++) begin
			master.recv_byte(d, i == n - 1);
			check(d, e0 + 8'(i));
		end
		master.stop_cond();
		check({6'h00, selected, sda_oe}, 8'h00);
	endtask

	// Address counter wraps from the top location to zero.
	task automatic t_wrap();
		wr_bytes(13'h1FFF, 8'hA5, 2, 99);
		rd_check(13'h1FFF, 8'hA5, 2);
	endtask

	// Only the strapped select code and the type code get an ack.
	task automatic t_select();
		logic k;
		for (int c = 0; c < 9; c++) begin
			master.start_cond();
			master.send_byte(c < 8 ? {TID, 3'(c), 1'b0} : {TID ^ 4'h8, PINS, 1'b0}, k);
			check({7'h00, k}, {7'h00, c == 8 || 3'(c) != PINS});
			master.stop_cond();
		end
	endtask

	// Protected writes are dropped; reads still work.
	task automatic t_wp();
		wr_bytes(13'h0010, 8'h11, 1, 99);
		@(posedge clk);
		wp <= 1'b1;
		n_rej = 0;
		wr_bytes(13'h0010, 8'h77, 1, 99);
		check(8'(n_rej), 8'h01);
		rd_check(13'h0010, 8'h11, 1);
		@(posedge clk);
		wp <= 1'b0;
	endtask

	// Hold the array so the write buffer fills and refuses, then drain it.
	task automatic t_fifo();
		@(posedge clk);
		hold <= 1'b1;
		wr_bytes(13'h0100, 8'h40, 9, 8);
		@(posedge clk);
		hold <= 1'b0;
		repeat (20) @(posedge clk);
		rd_check(13'h0100, 8'h40, 8);
	endtask

	// Stop in mid-byte abandons the transfer.
	task automatic t_abort();
		logic k;
		master.start_cond();
		master.send_byte({TID, PINS, 1'b0}, k);
		for (int i = 0; i < 4; i++) begin
			master.xfer_bit(1'b0, k);
		end
		master.stop_cond();
		check({7'h00, selected}, 8'h00);
		rd_check(13'h1FFF, 8'hA5, 1);
	endtask

	initial begin
		rst = 1'b1;
		wp = 1'b0;
		hold = 1'b0;
		pins = 3'h0;
		errors = 0;
		n_checks = 0;
		n_rej = 0;
		cycles = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		pins <= PINS;
		repeat (8) @(posedge clk);
		t_select();
		t_wrap();
		t_wp();
		t_fifo();
		t_abort();
		finish_test();
	end
endmodule

`default_nettype wire
